// ==== rtl/output_cell_bank.sv ====
/*
  Bank of programmable output cells: per-cell polarity, registered or
  combinational path, enable source and feedback source, with a register
  port holding the configuration and showing cell state.
  Assumes sum and enable terms come from array logic on ref_clk; the pin
  levels and the dedicated enable pin come from outside and are
  synchronised here. The testbench resolves the pin wires from pin_oe.
*/
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ns

module output_cell_bank
  import output_cell_pkg::*;
#(
  parameter int NUM_CELLS = CELL_COUNT
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // Register port
  input wire reg_req_t req,
  output logic [DATA_W-1:0] rdata,
  // Array side
  input wire logic [NUM_CELLS-1:0] sum_term,
  input wire logic [NUM_CELLS-1:0] oe_term,
  output logic [NUM_CELLS-1:0] feedback,
  // Pins
  input wire logic oe_pin_n,
  input wire logic [NUM_CELLS-1:0] pin_in,
  output logic [NUM_CELLS-1:0] pin_out,
  output logic [NUM_CELLS-1:0] pin_oe
);

  // Status words show one bit per cell in a 32-bit word
  if (NUM_CELLS < 1 || NUM_CELLS > 10) begin : g_bad_count
    $error("NUM_CELLS must lie between 1 and 10");
  end

  typedef struct packed {
    cell_cfg_t [NUM_CELLS-1:0] cfg;
    logic [NUM_CELLS-1:0] q;
    logic [NUM_CELLS-1:0] pin_s1;
    logic [NUM_CELLS-1:0] pin_s2;
    logic oe_n_s1;
    logic oe_n_s2;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  logic [NUM_CELLS-1:0] pol_v;
  logic [NUM_CELLS-1:0] comb_v;
  logic [NUM_CELLS-1:0] src_v;
  logic [NUM_CELLS-1:0] fbsel_v;
  logic [NUM_CELLS-1:0] raw_val;
  logic [DATA_W-1:0] pad_zero;
  logic [5:0] word_idx;
  logic cfg_hit;

  assign pad_zero = '0;
  assign word_idx = req.addr[7:2];
  // A cell word lies on an aligned address below the status block
  assign cfg_hit = (req.addr[1:0] == 2'h0) &&
                   (int'(word_idx) < NUM_CELLS);

  // Per-cell output path
  for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
    assign pol_v[i] = state_ff.cfg[i].polarity_select_bit;
    assign comb_v[i] = state_ff.cfg[i].registered_or_comb_bit;
    assign src_v[i] = state_ff.cfg[i].enable_source_bit;
    assign fbsel_v[i] = state_ff.cfg[i].feedback_source_bit;
    // Combinational mode bypasses the register for the pin; register feedback still shows q
    assign raw_val[i] = comb_v[i] ? sum_term[i] : state_ff.q[i];
    // Polarity inverts the chosen value when the bit is clear
    assign pin_out[i] = pol_v[i] ? raw_val[i] : ~raw_val[i];
    // Enable pin is active low, the product term active high
    assign pin_oe[i] = src_v[i] ? oe_term[i] : ~state_ff.oe_n_s2;
    // Pin feedback sees the pin level even while not driving
    assign feedback[i] = fbsel_v[i] ? state_ff.pin_s2[i]
                                    : state_ff.q[i];
  end

  assign rdata = state_ff.rdata;

  always_comb begin
    nxt_state = state_ff;
    // Read data freezes with ce low too, so a stalled read keeps its word
    if (ce) begin
      nxt_state.rdata = '0;
      // Cell register follows the sum term on every enabled edge
      nxt_state.q = sum_term;
      nxt_state.pin_s1 = pin_in;
      nxt_state.pin_s2 = state_ff.pin_s1;
      nxt_state.oe_n_s1 = oe_pin_n;
      nxt_state.oe_n_s2 = state_ff.oe_n_s1;
      // Each word touches only its own cell
      if (req.wr && cfg_hit) begin
        nxt_state.cfg[word_idx] = req.wdata[CFG_BITS-1:0];
      end
      if (req.rd) begin
        if (cfg_hit) begin
          nxt_state.rdata = {pad_zero[DATA_W-1:CFG_BITS],
                             state_ff.cfg[word_idx]};
        end else begin
          // Drive state shows the live enable, not a registered copy
          case (req.addr)
            CELL_STATE_ADDR: begin
              nxt_state.rdata = {pad_zero[DATA_W-1:NUM_CELLS],
                                 state_ff.q};
            end
            PIN_LEVEL_ADDR: begin
              nxt_state.rdata = {pad_zero[DATA_W-1:NUM_CELLS],
                                 state_ff.pin_s2};
            end
            DRIVE_STATE_ADDR: begin
              nxt_state.rdata = {pad_zero[DATA_W-1:NUM_CELLS], pin_oe};
            end
            FEEDBACK_ADDR: begin
              nxt_state.rdata = {pad_zero[DATA_W-1:NUM_CELLS],
                                 feedback};
            end
            default: begin
              nxt_state.rdata = '0;
            end
          endcase
        end
      end
    end
  end

  // Reset wins over the clock enable so a frozen bank still starts blank
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff.cfg <= {NUM_CELLS{CFG_RESET}};
      state_ff.q <= {NUM_CELLS{CELL_Q_RESET}};
      state_ff.pin_s1 <= '0;
      state_ff.pin_s2 <= '0;
      state_ff.oe_n_s1 <= OE_PIN_RESET;
      state_ff.oe_n_s2 <= OE_PIN_RESET;
      state_ff.rdata <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // Registered active-high cell shows last captured sum term
  reg_path_a: assert property (
    ce && !req.wr && !comb_v[0] && pol_v[0]
    |=> pin_out[0] == $past(sum_term[0])
  ) else $error("registered path does not show captured term");

  comb_high_a: assert property (
    comb_v[0] && pol_v[0] |-> pin_out[0] == sum_term[0]
  ) else $error("active high combinational output wrong");

  comb_low_a: assert property (
    comb_v[0] && !pol_v[0] |-> pin_out[0] == !sum_term[0]
  ) else $error("active low combinational output wrong");

  // Enable pin reaches the driver after two synchronising edges
  oe_pin_path_a: assert property (
    !src_v[0] && $past(ce) && $past(ce, 2) &&
    !$past(reset) && !$past(reset, 2)
    |-> pin_oe[0] == !$past(oe_pin_n, 2)
  ) else $error("enable pin not followed after two edges");

  oe_term_path_a: assert property (
    src_v[0] |-> pin_oe[0] == oe_term[0]
  ) else $error("enable product term not followed");

  fb_register_a: assert property (
    !fbsel_v[0] && !comb_v[0] && pol_v[0] |-> feedback[0] == pin_out[0]
  ) else $error("register feedback differs from register output");

  fb_pin_a: assert property (
    fbsel_v[0] && $past(ce) && $past(ce, 2) &&
    !$past(reset) && !$past(reset, 2)
    |-> feedback[0] == $past(pin_in[0], 2)
  ) else $error("pin feedback does not follow pin level");

  // After reset a blank cell shows a high output level with low register feedback
  blank_start_a: assert property (
    $past(reset) |-> pin_out == '1 && feedback == '0 && !comb_v[0]
  ) else $error("blank state after reset wrong");

  cell_isolate_a: assert property (
    ce && req.wr && req.addr == CFG_BASE_ADDR
    |=> $stable(state_ff.cfg[NUM_CELLS-1:1])
  ) else $error("write to cell zero changed another cell");

  read_timing_a: assert property (
    ce && req.rd && req.addr == FEEDBACK_ADDR
    |=> rdata[0] == $past(feedback[0])
  ) else $error("read data not presented one cycle later");

  // Every enabled edge loads the sum terms into the cell registers
  reg_capture_a: assert property (
    ce |=> state_ff.q == $past(sum_term)
  ) else $error("cell register did not capture the sum term");

  // A low clock enable must leave registers and configuration alone
  ce_freeze_a: assert property (
    !ce |=> $stable(state_ff.q) && $stable(state_ff.cfg)
  ) else $error("state moved while the clock enable was low");

  blank_cfg_a: assert property (
    $past(reset) |-> state_ff.cfg == '0 && state_ff.q == '0
  ) else $error("configuration or register not blank after reset");

  // Drivers stay off until the enable pin has passed the synchroniser
  reset_drive_a: assert property (
    $past(reset) |-> pin_oe == '0
  ) else $error("a cell drives its pin straight after reset");

  cfg_write_a: assert property (
    ce && req.wr && req.addr == CFG_BASE_ADDR
    |=> state_ff.cfg[0] == $past(req.wdata[CFG_BITS-1:0])
  ) else $error("configuration write did not land in cell zero");

  cfg_read_a: assert property (
    ce && req.rd && req.addr == CFG_BASE_ADDR
    |=> rdata == {pad_zero[DATA_W-1:CFG_BITS], $past(state_ff.cfg[0])}
  ) else $error("configuration read of cell zero wrong");

  state_read_a: assert property (
    ce && req.rd && req.addr == CELL_STATE_ADDR
    |=> rdata[NUM_CELLS-1:0] == $past(state_ff.q)
  ) else $error("cell state read wrong");

  pin_read_a: assert property (
    ce && req.rd && req.addr == PIN_LEVEL_ADDR
    |=> rdata[NUM_CELLS-1:0] == $past(state_ff.pin_s2)
  ) else $error("pin level read wrong");

  drive_read_a: assert property (
    ce && req.rd && req.addr == DRIVE_STATE_ADDR
    |=> rdata[NUM_CELLS-1:0] == $past(pin_oe)
  ) else $error("drive state read wrong");

  // Holes in the map read as zero rather than aliasing a cell
  hole_read_a: assert property (
    ce && req.rd && !cfg_hit && req.addr > FEEDBACK_ADDR
    |=> rdata == '0
  ) else $error("unmapped address returned data");

  // The same path rules hold in every cell, not only in cell zero
  for (genvar k = 0; k < NUM_CELLS; k++) begin : g_cell_chk
    cell_reg_a: assert property (
      ce && !req.wr && !comb_v[k]
      |=> pin_out[k] == ($past(sum_term[k]) ~^ pol_v[k])
    ) else $error("registered output wrong in a cell");

    cell_comb_a: assert property (
      comb_v[k] |-> pin_out[k] == (sum_term[k] ~^ pol_v[k])
    ) else $error("combinational output wrong in a cell");

    cell_oe_a: assert property (
      src_v[k] |-> pin_oe[k] == oe_term[k]
    ) else $error("enable term not followed in a cell");

    cell_fb_a: assert property (
      !fbsel_v[k] |-> feedback[k] == state_ff.q[k]
    ) else $error("register feedback wrong in a cell");

    cell_oe_pin_a: assert property (
      !src_v[k] && $past(ce) && $past(ce, 2) &&
      !$past(reset) && !$past(reset, 2)
      |-> pin_oe[k] == !$past(oe_pin_n, 2)
    ) else $error("enable pin not followed in a cell");

    cell_fb_pin_a: assert property (
      fbsel_v[k] && $past(ce) && $past(ce, 2) &&
      !$past(reset) && !$past(reset, 2)
      |-> feedback[k] == $past(pin_in[k], 2)
    ) else $error("pin feedback wrong in a cell");
  end

  // Main scenarios
  comb_enabled_c: cover property (comb_v[0] && pol_v[0] && pin_oe[0]);
  term_disabled_c: cover property (src_v[0] && !pin_oe[0]);
  pin_feedback_c: cover property (fbsel_v[0] && !pin_oe[0] && pin_in[0]);
  reg_low_c: cover property (!comb_v[0] && !pol_v[0] && pin_oe[0]);
  freeze_write_c: cover property (!ce && req.wr);

endmodule : output_cell_bank

// ==== rtl/output_cell_pkg.sv ====
/*
  Constants, register map and carrier types for the programmable output
  cell bank.
  Assumes a single clock domain and a plain strobe-based register port.
*/
package output_cell_pkg;

  // Bank geometry
  localparam int CELL_COUNT = 10;
  localparam int CFG_BITS = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Positions of the four configuration bits inside a cell word
  localparam int POL_BIT_POS = 0;
  localparam int PATH_BIT_POS = 1;
  localparam int OE_SRC_BIT_POS = 2;
  localparam int FB_BIT_POS = 3;

  // Values after reset: a blank cell reads all zero
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic CELL_Q_RESET = 1'b0;
  // Synchronised enable pin rests at its inactive (high) level
  localparam logic OE_PIN_RESET = 1'b1;

  // Register map, byte addresses, one aligned word each
  localparam logic [ADDR_W-1:0] CFG_BASE_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] CELL_STATE_ADDR = 8'h28;
  localparam logic [ADDR_W-1:0] PIN_LEVEL_ADDR = 8'h2c;
  localparam logic [ADDR_W-1:0] DRIVE_STATE_ADDR = 8'h30;
  localparam logic [ADDR_W-1:0] FEEDBACK_ADDR = 8'h34;

  // Configuration word of one cell, bit 0 is the polarity select
  typedef struct packed {
    logic feedback_source_bit;
    logic enable_source_bit;
    logic registered_or_comb_bit;
    logic polarity_select_bit;
  } cell_cfg_t;

  // Register port request from the controlling logic
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : output_cell_pkg

// ==== test/board_model.sv ====
/*
  Board model: resolves each pin wire from the cell drive and the board.
  Assumes the board drives every pin that its cell has released.
*/
`timescale 1ns/1ns
module board_model
  import output_cell_pkg::*;
#(
  parameter int N = CELL_COUNT
) (
  // Cell side
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe,
  // Board side
  input wire logic [N-1:0] board_lvl,
  output logic [N-1:0] pin_in
);
  // A released pin shows the board level, never the last driven value
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_lvl);
endmodule : board_model

// ==== test/output_cell_bank_tb_top.sv ====
/*
  Self-checking bench for the output cell bank: a table of configurations,
  then reset, enable source, feedback and register port cases.
  Assumes one clock and the board model on the pins.
*/
`timescale 1ns/1ns
module output_cell_bank_tb_top;
  import output_cell_pkg::*;
  localparam int N = CELL_COUNT;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic oe_pin_n = 1'b1;
  reg_req_t req = '0;
  logic [DATA_W-1:0] rdata;
  logic [N-1:0] sum_term = '0;
  logic [N-1:0] oe_term = '0;
  logic [N-1:0] board_lvl = '0;
  logic [N-1:0] feedback, pin_in, pin_out, pin_oe;
  int miscompares = 0;
  int checks = 0;
  int c;
  // Per row: cfg, sum, enable term, expected level, expected enable
  logic [7:0] rows [16] = '{8'h0b, 8'h19, 8'h29, 8'h31, 8'h4f, 8'h58,
    8'h68, 8'h7a, 8'h8b, 8'h99, 8'ha3, 8'hbb, 8'hca, 8'hdd, 8'he8, 8'hfa};

  output_cell_bank #(.NUM_CELLS(N)) dut (.ref_clk(ref_clk), .reset(reset),
    .ce(ce), .req(req), .rdata(rdata), .sum_term(sum_term),
    .oe_term(oe_term), .feedback(feedback), .oe_pin_n(oe_pin_n),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  board_model #(.N(N)) board (.pin_out(pin_out), .pin_oe(pin_oe),
    .board_lvl(board_lvl), .pin_in(pin_in));

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // Each access leaves one idle cycle so a strobe is never driven twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 check("rdata", rdata, exp);
  endtask : rd

  // Pin levels pass a two-flop synchroniser, so allow a few edges
  task automatic wait_fb(input logic exp);
    int n;
    // Never look in the time step of the edge that launches the value
    #1;
    for (n = 0; n < 8 && feedback[0] !== exp; n++) begin
      @(posedge ref_clk);
      #1;
    end
    check("feedback", 32'(feedback[0]), 32'(exp));
    if (n == 8) complete_run();
  endtask : wait_fb

  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    #1 check("pin_out", 32'(pin_out), 32'({N{1'b1}}));
    check("pin_oe", 32'(pin_oe), 32'h0);
    rd(CFG_BASE_ADDR, 32'h0);
    rd(CELL_STATE_ADDR, 32'h0);
    @(posedge ref_clk);
    oe_pin_n <= 1'b0;
    for (c = 0; c < 16; c++) begin
      wr(CFG_BASE_ADDR + 8'(4 * (c % N)), 32'(rows[c][7:4]));
      sum_term <= '0;
      @(posedge ref_clk);
      sum_term <= {N{rows[c][3]}};
      oe_term <= {N{rows[c][2]}};
      #1 check("level", 32'(pin_out[c % N]), 32'(rows[c][1]));
      check("enable", 32'(pin_oe[c % N]), 32'(rows[c][0]));
    end
    @(posedge ref_clk);
    oe_pin_n <= 1'b1;
    board_lvl <= '1;
    wait_fb(1'b1);
    board_lvl <= '0;
    wait_fb(1'b0);
    wr(CFG_BASE_ADDR, 32'h2);
    wait_fb(1'b1);
    @(posedge ref_clk);
    oe_term <= '1;
    #1 check("term enable", 32'(pin_oe[5]), 32'h1);
    check("pin enable", 32'(pin_oe[0]), 32'h0);
    rd(8'h40, 32'h0);
    rd(CFG_BASE_ADDR + 8'h14, 32'hf);
    rd(CFG_BASE_ADDR + 8'h10, 32'he);
    @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    #1 check("pin_oe", 32'(pin_oe), 32'h0);
    check("pin_out", 32'(pin_out), 32'({N{1'b1}}));
    rd(CFG_BASE_ADDR + 8'h14, 32'h0);
    // Clock enable low: register holds its one, the write is dropped
    @(posedge ref_clk);
    ce <= 1'b0;
    sum_term <= '0;
    wr(CFG_BASE_ADDR, 32'h1);
    #1 check("frozen", 32'(pin_out[0]), 32'h0);
    @(posedge ref_clk);
    ce <= 1'b1;
    rd(CFG_BASE_ADDR, 32'h0);
    check("released", 32'(pin_out[0]), 32'h1);
    // Status words on a blank bank with the pins released to the board
    @(posedge ref_clk);
    sum_term <= 10'h0f0;
    board_lvl <= 10'h2a5;
    rd(CELL_STATE_ADDR, 32'h0f0);
    rd(PIN_LEVEL_ADDR, 32'h2a5);
    rd(DRIVE_STATE_ADDR, 32'h0);
    rd(FEEDBACK_ADDR, 32'h0f0);
    wr(CFG_BASE_ADDR, 32'h8);
    rd(FEEDBACK_ADDR, 32'h0f1);
    complete_run();
  end
endmodule : output_cell_bank_tb_top
